// ==== common/rx_stat_pkg.sv ====
`default_nettype none
package rx_stat_pkg;
    // Lane count and field widths of the receive status outputs
    localparam int LANES_NUM       = 4;
    localparam int MISMATCH_W      = 8;
    localparam int BAD_CODE_W      = 2;
    localparam int FRAMING_W       = 4;
    // Reset values of the status levels
    localparam logic [3:0] LOCK_RST    = 4'h0;
    localparam logic       ALIGNED_RST = 1'b0;
    localparam logic       ALIGN_ERR_RST = 1'b0;
    localparam logic       FAULT_RST   = 1'b1;
endpackage
`default_nettype wire

// ==== hdl/lane_incr_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module lane_incr_stage #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             event_in,
    input  wire logic [WIDTH-1:0] count_in,
    output logic      [WIDTH-1:0] incr_out,
    output logic                  valid_out
);
    logic [WIDTH-1:0] incr_ff;
    logic             valid_ff;
    wire  [WIDTH-1:0] nxt_incr = event_in ? count_in : '0;

    if (WIDTH < 1) begin : g_bad_width
        $error("lane_incr_stage: WIDTH must be positive");
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            incr_ff  <= '0;
            valid_ff <= 1'b0;
        end else begin
            incr_ff  <= nxt_incr;
            valid_ff <= event_in;
        end
    end

    assign incr_out  = incr_ff;
    assign valid_out = valid_ff;

    quiet_zero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !valid_ff |-> incr_ff == '0) else $error("increment nonzero without valid");
    follow_event_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !event_in |=> !valid_ff) else $error("valid held without event");
endmodule
`default_nettype wire

// ==== hdl/pcs_rx_lane_status_stats.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcs_rx_lane_status_stats
    import rx_stat_pkg::*;
#(
    parameter int LANES = LANES_NUM
) (
    input  wire logic                  clk_in,
    input  wire logic                  arst_n_in,
    input  wire logic                  test_pattern_en_in,
    input  wire logic [LANES-1:0]      lane_lock_in,
    input  wire logic [LANES-1:0]      lane_deskewed_in,
    input  wire logic                  align_fail_in,
    input  wire logic                  mismatch_event_in,
    input  wire logic [MISMATCH_W-1:0] mismatch_count_in,
    input  wire logic                  bad_code_event_in,
    input  wire logic [BAD_CODE_W-1:0] bad_code_count_in,
    input  wire logic [LANES-1:0]      sync_err_event_in,
    input  wire logic [LANES*FRAMING_W-1:0] sync_err_count_in,
    output logic      [LANES-1:0]      block_lock_out,
    output logic      [MISMATCH_W-1:0] mismatch_incr_out,
    output logic                       mismatch_valid_out,
    output logic      [BAD_CODE_W-1:0] bad_code_incr_out,
    output logic                       bad_code_valid_out,
    output logic      [LANES*FRAMING_W-1:0] framing_incr_out,
    output logic      [LANES-1:0]      framing_valid_out,
    output logic                       aligned_out,
    output logic                       local_fault_out,
    output logic                       align_err_out
);
    // ==========================================================
    // Status levels
    logic [LANES-1:0] lock_ff;
    logic             aligned_ff;
    logic             fault_ff;
    logic             align_err_ff;
    logic             was_aligned_ff;

    // Port fields and reset constants are laid out for exactly four lanes
    if (LANES != LANES_NUM) begin : g_bad_lanes
        $error("LANES must match the four lane PCS");
    end

    wire all_aligned = (&lane_deskewed_in) && (&lane_lock_in);
    wire align_loss  = was_aligned_ff && !all_aligned;
    wire nxt_align_err = align_fail_in || align_loss;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lock_ff        <= LOCK_RST;
            aligned_ff     <= ALIGNED_RST;
            fault_ff       <= FAULT_RST;
            align_err_ff   <= ALIGN_ERR_RST;
            was_aligned_ff <= 1'b0;
        end else begin
            lock_ff        <= lane_lock_in;
            aligned_ff     <= all_aligned;
            fault_ff       <= !all_aligned;
            align_err_ff   <= nxt_align_err;
            was_aligned_ff <= all_aligned;
        end
    end

    assign block_lock_out  = lock_ff;
    assign aligned_out     = aligned_ff;
    assign local_fault_out = fault_ff;
    assign align_err_out   = align_err_ff;

    // ==========================================================
    // Increment stages
    // gate by test enable
    wire mismatch_ok = mismatch_event_in && test_pattern_en_in && (mismatch_count_in != '0);

    lane_incr_stage #(.WIDTH(MISMATCH_W)) mismatch_stage (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .event_in  (mismatch_ok),
        .count_in  (mismatch_count_in),
        .incr_out  (mismatch_incr_out),
        .valid_out (mismatch_valid_out)
    );

    lane_incr_stage #(.WIDTH(BAD_CODE_W)) bad_code_stage (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .event_in  (bad_code_event_in),
        .count_in  (bad_code_count_in),
        .incr_out  (bad_code_incr_out),
        .valid_out (bad_code_valid_out)
    );

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            lane_incr_stage #(.WIDTH(FRAMING_W)) framing_stage (
                .clk_in    (clk_in),
                .arst_n_in (arst_n_in),
                .event_in  (sync_err_event_in[g]),
                .count_in  (sync_err_count_in[g*FRAMING_W +: FRAMING_W]),
                .incr_out  (framing_incr_out[g*FRAMING_W +: FRAMING_W]),
                .valid_out (framing_valid_out[g])
            );
        end
    endgenerate

    // ==========================================================
    // Checks
    // lock follows lanes
    lock_follow_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> block_lock_out == $past(lane_lock_in)) else $error("lock flag wrong");

    mismatch_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !test_pattern_en_in |=> !mismatch_valid_out) else $error("mismatch while disabled");

    mismatch_off_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !test_pattern_en_in |=> mismatch_incr_out == '0)
        else $error("mismatch value while disabled");

    mismatch_value_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        mismatch_ok |=> mismatch_valid_out && mismatch_incr_out == $past(mismatch_count_in))
        else $error("mismatch value lost");

    mismatch_pulse_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !mismatch_ok |=> mismatch_incr_out == '0) else $error("mismatch held");

    mismatch_strobe_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        mismatch_incr_out != '0 |-> mismatch_valid_out) else $error("no mismatch strobe");

    strobe_nonzero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        mismatch_valid_out |-> mismatch_incr_out != '0)
        else $error("mismatch strobe with zero count");

    bad_code_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        bad_code_event_in |=> bad_code_valid_out && bad_code_incr_out == $past(bad_code_count_in))
        else $error("code violation lost");

    bad_code_zero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !bad_code_valid_out |-> bad_code_incr_out == '0) else $error("code incr no strobe");

    bad_code_quiet_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !bad_code_event_in |=> !bad_code_valid_out) else $error("code strobe without event");

    framing_lane0_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        sync_err_event_in[0] |=> framing_valid_out[0]) else $error("framing strobe lost");

    framing_zero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !framing_valid_out[1] |-> framing_incr_out[7:4] == '0) else $error("framing no strobe");

    for (g = 0; g < LANES; g++) begin : g_lane_chk
        framing_value_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
            sync_err_event_in[g] |=> framing_valid_out[g]
                && framing_incr_out[g*FRAMING_W +: FRAMING_W]
                == $past(sync_err_count_in[g*FRAMING_W +: FRAMING_W]))
            else $error("framing count lost");
        framing_quiet_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
            !framing_valid_out[g] |-> framing_incr_out[g*FRAMING_W +: FRAMING_W] == '0)
            else $error("framing count without strobe");
    end

    aligned_all_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        aligned_out |-> $past(&lane_deskewed_in) && $past(&lane_lock_in))
        else $error("aligned without all lanes");

    aligned_follow_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> aligned_out == $past(all_aligned)) else $error("aligned flag stale");

    fault_level_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        local_fault_out == !aligned_out) else $error("fault not inverse of aligned");

    loss_error_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        aligned_out && !all_aligned |=> align_err_out) else $error("alignment loss missed");

    fail_error_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        align_fail_in |=> align_err_out) else $error("aligner failure missed");

    err_cause_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        align_err_out |-> $past(align_fail_in) || ($past(aligned_out) && !$past(all_aligned)))
        else $error("alignment error without cause");

    reset_clear_a: assert property (@(posedge clk_in)
        !arst_n_in ##1 !arst_n_in |-> block_lock_out == LOCK_RST && aligned_out == ALIGNED_RST
            && local_fault_out == FAULT_RST && align_err_out == ALIGN_ERR_RST
            && !mismatch_valid_out && !bad_code_valid_out && framing_valid_out == '0)
        else $error("outputs not cleared in reset");
endmodule
`default_nettype wire

// ==== tb/pcs_rx_lane_status_stats_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcs_rx_lane_status_stats_tb;
    import rx_stat_pkg::*;
    logic        clk_in = 1'b0, arst_n_in, test_pattern_en_in, align_fail_in;
    logic        mismatch_event_in, bad_code_event_in, started = 1'b0, p_en, p_fail;
    logic [3:0]  lane_lock_in, lane_deskewed_in, sync_err_event_in, p_lock, p_desk, p_se;
    logic [7:0]  mismatch_count_in, p_mc, mismatch_incr_out;
    logic [1:0]  bad_code_count_in, p_bc, bad_code_incr_out;
    logic [15:0] sync_err_count_in, p_sc, framing_incr_out;
    logic [3:0]  block_lock_out, framing_valid_out;
    logic        mismatch_valid_out, bad_code_valid_out, aligned_out, local_fault_out;
    logic        align_err_out, p_me, p_be, ok_prev = 1'b0, mev;
    int          n_errors = 0, comparisons = 0, seed = 81, exp_sum = 0, drop_age = 9;
    int          mis_q, mis_raw, bad_q, bad_raw, frm_q, frm_raw;
    // ==========================================
    // Device and statistics consumers
    pcs_rx_lane_status_stats pcs_rx_lane_status_stats_inst (.clk_in, .arst_n_in,
        .test_pattern_en_in, .lane_lock_in, .lane_deskewed_in, .align_fail_in,
        .mismatch_event_in, .mismatch_count_in, .bad_code_event_in, .bad_code_count_in,
        .sync_err_event_in, .sync_err_count_in, .block_lock_out, .mismatch_incr_out,
        .mismatch_valid_out, .bad_code_incr_out, .bad_code_valid_out, .framing_incr_out,
        .framing_valid_out, .aligned_out, .local_fault_out, .align_err_out);
    stat_sink mis_sink (.clk_in, .valid_in(mismatch_valid_out), .incr_in(mismatch_incr_out),
        .sum_q_out(mis_q), .sum_raw_out(mis_raw));
    stat_sink bad_sink (.clk_in, .valid_in(bad_code_valid_out),
        .incr_in({6'h00, bad_code_incr_out}), .sum_q_out(bad_q), .sum_raw_out(bad_raw));
    stat_sink frm_sink (.clk_in, .valid_in(framing_valid_out[0]),
        .incr_in({4'h0, framing_incr_out[3:0]}), .sum_q_out(frm_q), .sum_raw_out(frm_raw));
    always #2.5 clk_in = ~clk_in;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // Reference model: outputs are their inputs one cycle late, align_err_out also uses the lane state of two cycles back
    always @(posedge clk_in) begin
        if (arst_n_in === 1'b1) begin
            {p_en, p_lock, p_desk, p_fail, p_me, p_mc} = {test_pattern_en_in, lane_lock_in,
                lane_deskewed_in, align_fail_in, mismatch_event_in, mismatch_count_in};
            {p_be, p_bc, p_se, p_sc} = {bad_code_event_in, bad_code_count_in,
                sync_err_event_in, sync_err_count_in};
            drop_age = (ok_prev && !(&{p_lock, p_desk})) ? 0 : drop_age + 1;
            ok_prev = &{p_lock, p_desk};
            started = 1'b1;
        end
    end
    always @(negedge clk_in) begin
        if (started) begin
            mev = p_en && p_me && (p_mc != 8'h00);
            exp_sum += mev ? int'(p_mc) : 0;
            check(16'(block_lock_out), 16'(p_lock));
            check(16'(mismatch_valid_out), 16'(mev));
            check(16'(mismatch_incr_out), mev ? 16'(p_mc) : 16'h0000);
            check(16'(bad_code_valid_out), 16'(p_be));
            check(16'(bad_code_incr_out), p_be ? 16'(p_bc) : 16'h0000);
            check(16'(framing_valid_out), 16'(p_se));
            for (int g = 0; g < 4; g++) begin
                check(16'(framing_incr_out[4*g+:4]), p_se[g] ? 16'(p_sc[4*g+:4]) : 16'h0);
            end
            check(16'(aligned_out), 16'(&{p_lock, p_desk}));
            check(16'(local_fault_out), 16'(!(&{p_lock, p_desk})));
            check(16'(align_err_out), 16'(p_fail || (drop_age == 0)));
        end
    end
    initial begin
        {arst_n_in, test_pattern_en_in, align_fail_in, mismatch_event_in} = 4'h0;
        {bad_code_event_in, lane_lock_in, lane_deskewed_in, sync_err_event_in} = 13'h0000;
        {mismatch_count_in, bad_code_count_in, sync_err_count_in} = 26'h0000000;
        repeat (4) @(posedge clk_in);
        #1;
        check({block_lock_out, mismatch_incr_out, framing_valid_out}, 16'h0000);
        check({aligned_out, local_fault_out, align_err_out, mismatch_valid_out}, 16'h4);
        arst_n_in = 1'b1;
        $display("reset test done");
        // Lanes mostly all up, so alignment is gained and lost often
        repeat (3000) begin
            @(posedge clk_in);
            #1;
            {test_pattern_en_in, mismatch_event_in, bad_code_event_in} = 3'($random(seed));
            lane_lock_in = ($random(seed) & 7) ? 4'hf : 4'($random(seed));
            lane_deskewed_in = ($random(seed) & 7) ? 4'hf : 4'($random(seed));
            align_fail_in = (($random(seed) & 15) == 0);
            mismatch_count_in = ($random(seed) & 3) ? 8'($random(seed)) : 8'h00;
            {bad_code_count_in, sync_err_event_in, sync_err_count_in} = 22'($random(seed));
        end
        $display("random traffic test done");
        {mismatch_event_in, bad_code_event_in, sync_err_event_in} = 6'h00;
        repeat (3) @(posedge clk_in);
        #1;
        check(16'(mis_q), 16'(exp_sum));
        check(16'(mis_raw), 16'(mis_q));
        check(16'(bad_raw), 16'(bad_q));
        check(16'(frm_raw), 16'(frm_q));
        $display("consumer totals test done");
        test_done();
    end
    initial begin
        #40000;
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire

// ==== tb/stat_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Statistics consumer: sums qualified and raw increments
module stat_sink (
    input  wire logic       clk_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] incr_in,
    output int              sum_q_out,
    output int              sum_raw_out
);
    initial begin
        sum_q_out = 0;
        sum_raw_out = 0;
    end
    always @(posedge clk_in) begin
        if (valid_in === 1'b1)
            sum_q_out <= sum_q_out + int'(incr_in);
        sum_raw_out <= sum_raw_out + int'(incr_in);
    end
endmodule
`default_nettype wire
